// ===== core/sram_port_pkg.sv
// Shared constants, types and helpers for the synchronous SRAM port.
//
// What this block does
// - Enabled, selected, load low: take the address, start a read or a write.
// - Advance high while enabled, outside idle, steps the 2-bit burst counter and continues the access.
// - Read/write is ignored during bursts; the direction comes from the load.
// - Load low while not selected deselects; the bus floats one cycle later.
// - Selected only when both low enables are low and the high enable is high.
// - Clock enable high blocks the edge; all state and the bus hold.
// - Suspended cycles after a read keep the same read word on the bus.
// - A loaded read shows its word in the cycle right after the address, enabled or not.
// - Active-low lane selects gate each 8-bit lane plus its parity bit.
// - Any lane combination may be written at once; narrow parts lack lanes 3 and 4.
// - Burst order high: low address bits are start XOR beat count.
// - Burst order low: low address bits step by one modulo four.
// - After four beats the counter wraps to its start and keeps counting.
// - The data bus stays high impedance from reset until a read is issued.
// - Address, control and write data are sampled only on the rising edge.
// - Load low ends any burst; while selected it takes a new address and command.
`default_nettype none

package sram_port_pkg;

  // ------------------------------------------------------------------
  // Widths and layout
  // ------------------------------------------------------------------
  localparam int ADDR_W   = 18;   // 256K words.
  localparam int DATA_W   = 36;   // 32 data bits plus 4 parity bits.
  localparam int LANES    = 4;
  localparam int LANE_DW  = 8;    // Data bits per lane.
  localparam int PAR_BASE = 32;   // Parity bit of lane k sits at PAR_BASE + k.
  localparam int CNT_W    = 2;    // Burst counter width.

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [LANES-1:0]  LANE_OFF = 4'hF;

  // Access in progress, i.e. what the next data cycle carries.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } acc_state_t;

  // One sampled command from the controller.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              read;
    logic              adv;
    logic [LANES-1:0]  lanes_n;
  } cmd_t;

  // Low address bits of a burst beat.
  function automatic logic [CNT_W-1:0] burst_low(input logic [CNT_W-1:0] start,
                                                 input logic [CNT_W-1:0] beat,
                                                 input logic             interleave);
    burst_low = interleave ? (start ^ beat) : CNT_W'(start + beat);
  endfunction

  // Bit mask of the lanes whose active-low select is asserted.
  function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] lanes_n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int k = 0; k < LANES; k++) begin
      if (!lanes_n[k]) begin
        m[k*LANE_DW +: LANE_DW] = '1;
        m[PAR_BASE + k] = 1'b1;
      end
    end
    lane_mask = m;
  endfunction

endpackage

`default_nettype wire

// ===== core/sram_port_mem.sv
// Word array with lane-masked write and registered read data.
`default_nettype none
`timescale 1ns/100ps

module sram_port_mem
  import sram_port_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data_r,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [DATA_W-1:0] wr_mask
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Only masked bits change, so untouched lanes keep their old contents.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Read data holds while rd_en is low, which keeps a suspended read on the bus.
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ===== core/sram_port.sv
// Command decode, burst counter and data bus control of the SRAM port.
`default_nettype none
`timescale 1ns/100ps

module sram_port
  import sram_port_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_gate_n,
  input  wire logic              select_a_n,
  input  wire logic              select_b,
  input  wire logic              select_c_n,
  input  wire logic              read_not_write,
  input  wire logic              advance_or_load,
  input  wire logic [LANES-1:0]  lane_write_n,
  input  wire logic              burst_order_sel,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe
);

  // ------------------------------------------------------------------
  // Command sampling and decode
  // ------------------------------------------------------------------
  cmd_t              cmd;
  acc_state_t        state_r;
  acc_state_t        state_nxt;
  logic [ADDR_W-1:0] base_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [ADDR_W-1:0] acc_addr_r;
  logic [ADDR_W-1:0] acc_addr_nxt;
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [LANES-1:0]  wr_lane_r;
  logic              dq_oe_r;
  logic              enabled;
  logic              selected;
  logic              do_load;
  logic              do_desel;
  logic              do_adv;
  logic              rd_en;
  logic              wr_fire;
  logic              new_write;
  logic [DATA_W-1:0] wr_mask;

  // All controller inputs come from logic on clk_sys and are used directly.
  assign cmd = '{addr:    addr,
                 read:    read_not_write,
                 adv:     advance_or_load,
                 lanes_n: lane_write_n};

  // A high clock enable blocks the whole edge, so every action needs it.
  assign enabled  = !clk_gate_n;
  assign selected = !select_a_n && !select_c_n && select_b;
  assign do_load  = enabled && !cmd.adv && selected;
  assign do_desel = enabled && !cmd.adv && !selected;
  // Advancing from idle is a no-op: nothing is read or written.
  assign do_adv   = enabled && cmd.adv && (state_r != ST_IDLE);

  // ------------------------------------------------------------------
  // Access state and burst counter
  // ------------------------------------------------------------------
  // Direction is only taken at a load; advances keep the loaded direction.
  always_comb begin
    state_nxt = state_r;
    if (do_load) begin
      state_nxt = cmd.read ? ST_READ : ST_WRITE;
    end else if (do_desel) begin
      state_nxt = ST_IDLE;
    end
  end

  // The counter is two bits wide, so the fourth step wraps to the start.
  always_comb begin
    cnt_nxt      = cnt_r;
    acc_addr_nxt = acc_addr_r;
    if (do_load) begin
      cnt_nxt      = CNT_RST;
      acc_addr_nxt = cmd.addr;
    end else if (do_adv) begin
      cnt_nxt      = CNT_W'(cnt_r + 2'h1);
      acc_addr_nxt = {base_r[ADDR_W-1:CNT_W],
                      burst_low(base_r[CNT_W-1:0], cnt_nxt, burst_order_sel)};
    end
  end

  // State, base address and counter update only on enabled edges.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= CNT_RST;
      acc_addr_r <= ADDR_RST;
    end else if (enabled) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      acc_addr_r <= acc_addr_nxt;
    end
  end

  // The burst base is the externally loaded address.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      base_r <= ADDR_RST;
    end else if (do_load) begin
      base_r <= cmd.addr;
    end
  end

  // ------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------
  // Lane selects go with each command beat; the data follow one enabled
  // cycle later, which is why address and lanes are held here.
  assign new_write = (do_load && !cmd.read) || (do_adv && state_r == ST_WRITE);
  assign wr_fire   = enabled && wr_pend_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= ADDR_RST;
      wr_lane_r <= LANE_OFF;
    end else if (enabled) begin
      wr_pend_r <= new_write;
      wr_addr_r <= acc_addr_nxt;
      wr_lane_r <= cmd.lanes_n;
    end
  end

  // ------------------------------------------------------------------
  // Read path and bus enable
  // ------------------------------------------------------------------
  // The array registers its word on the command edge, so the word is on
  // the bus during the following cycle with no further output stage.
  assign rd_en = (do_load && cmd.read) || (do_adv && state_r == ST_READ);

  // The bus drives only for a read beat; writes, deselects and no-ops float
  // it one cycle after their edge, and a suspended edge holds it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dq_oe_r <= 1'b0;
    end else if (enabled) begin
      dq_oe_r <= rd_en;
    end
  end

  assign dq_oe = dq_oe_r;

  // Lane selects widen to a bit mask once, shared by the array and a check.
  assign wr_mask = lane_mask(wr_lane_r);

  sram_port_mem sram_port_mem_i (
    .clk_sys   (clk_sys),
    .rd_en     (rd_en),
    .rd_addr   (acc_addr_nxt),
    .rd_data_r (dq_o),
    .wr_en     (wr_fire),
    .wr_addr   (wr_addr_r),
    .wr_data   (dq_i),
    .wr_mask   (wr_mask)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // A loaded read drives the bus in the next cycle.
  a_load_read_drives: assert property (
    do_load && cmd.read |=> dq_oe && state_r == ST_READ)
    else $error("load read did not drive the bus");

  // A loaded write releases the bus in the next cycle.
  a_load_write_floats: assert property (
    do_load && !cmd.read |=> !dq_oe && wr_pend_r)
    else $error("load write left the bus driven");

  // Deselect floats the bus and stays floating through no-ops.
  a_desel_floats: assert property (
    do_desel ##1 (enabled && cmd.adv) |=> !dq_oe && state_r == ST_IDLE)
    else $error("deselect or no-op drove the bus");

  // A suspended edge keeps the bus and its read word unchanged.
  a_suspend_holds: assert property (
    !enabled |=> $stable(dq_oe) && $stable(dq_o) && $stable(state_r))
    else $error("suspended edge changed bus or state");

  // The access direction survives any advance.
  a_burst_dir_kept: assert property (
    do_adv |=> state_r == $past(state_r))
    else $error("burst changed direction");

  // Linear order steps the low bits by one.
  a_linear_step: assert property (
    do_adv && !burst_order_sel |=>
      acc_addr_r[1:0] == CNT_W'($past(acc_addr_r[1:0]) + 2'h1))
    else $error("linear burst step wrong");

  // Interleaved order: second beat is start with bit 0 flipped.
  a_interleave_step: assert property (
    do_load ##1 (do_adv && burst_order_sel) |=>
      acc_addr_r == ($past(acc_addr_r) ^ 18'h00001))
    else $error("interleaved burst step wrong");

  // Four advances bring the address back to the loaded value.
  a_burst_wraps: assert property (
    do_load ##1 do_adv[*4] |=> acc_addr_r == $past(acc_addr_r, 4))
    else $error("burst did not wrap after four beats");

  // Any deasserted enable blocks a load.
  a_select_gate: assert property (
    enabled && !cmd.adv && (select_a_n || select_c_n || !select_b) |=> state_r == ST_IDLE)
    else $error("device loaded while not selected");

  // The bus floats right after reset.
  a_reset_floats: assert property (
    disable iff (1'b0) sys_rst |=> !dq_oe)
    else $error("bus driven after reset");

  // All lanes off leaves the stored word untouched.
  a_no_lane_write: assert property (
    wr_fire && wr_lane_r == LANE_OFF |=>
      sram_port_mem_i.mem[$past(wr_addr_r)] == $past(sram_port_mem_i.mem[wr_addr_r]))
    else $error("write with no lanes selected changed data");

  // ------------------------------------------------------------------
  // Burst, array and write-path checks
  // ------------------------------------------------------------------
  // Some of these look into the array so that they judge stored words.

  // A load restarts the counter at the external address.
  a_load_ends_burst: assert property (
    do_load |=> cnt_r == CNT_RST && acc_addr_r == $past(addr))
    else $error("load did not restart the burst");

  // A loaded write takes its data at the next enabled edge.
  a_write_lands: assert property (
    do_load && !cmd.read ##1 enabled |-> wr_fire && wr_addr_r == $past(addr))
    else $error("loaded write did not land at the next edge");

  // A loaded read shows the stored word in the next cycle.
  a_read_word: assert property (
    do_load && cmd.read |=> dq_o == $past(sram_port_mem_i.mem[addr]))
    else $error("loaded read showed the wrong word");

  // Every advance steps the burst counter by one.
  a_counter_step: assert property (
    do_adv |=> cnt_r == CNT_W'($past(cnt_r) + 2'h1))
    else $error("burst counter did not step");

  // A read advance keeps the bus driven with the next word.
  a_read_burst_drives: assert property (
    do_adv && state_r == ST_READ |=> dq_oe)
    else $error("read advance released the bus");

  // A write advance floats the bus and owes one data beat.
  a_write_burst_pends: assert property (
    do_adv && state_r == ST_WRITE |=> !dq_oe && wr_pend_r)
    else $error("write advance drove the bus or lost its data beat");

  // Lane 1 owns bits 0 to 7 and the first parity bit; lane 4 the top parity bit.
  a_lane_map: assert property (
    wr_fire |-> wr_mask[LANE_DW-1:0] == {LANE_DW{!wr_lane_r[0]}} &&
      wr_mask[PAR_BASE] == !wr_lane_r[0] && wr_mask[DATA_W-1] == !wr_lane_r[LANES-1])
    else $error("lane select mapped to the wrong bits");

  // A deselect floats the bus in the next cycle even without a no-op.
  a_desel_release: assert property (
    do_desel |=> !dq_oe && state_r == ST_IDLE)
    else $error("deselect left the bus driven");

  // An advance from idle changes nothing and writes nothing.
  a_noop_idle: assert property (
    enabled && cmd.adv && state_r == ST_IDLE |=> !dq_oe && !wr_pend_r)
    else $error("no-op started an access");

  // Interleaved beats are the loaded low bits XOR the beat count.
  a_interleave_any: assert property (
    do_adv && burst_order_sel |=> acc_addr_r[1:0] == (base_r[1:0] ^ cnt_r))
    else $error("interleaved beat address wrong");

  // The fourth advance brings the burst back to the loaded address.
  a_wraps_to_start: assert property (
    do_adv && cnt_r == 2'h3 |=> acc_addr_r == base_r)
    else $error("burst did not return to its start");

  // A burst only moves the two low address bits.
  a_high_bits_kept: assert property (
    do_adv |=> acc_addr_r[ADDR_W-1:CNT_W] == $past(acc_addr_r[ADDR_W-1:CNT_W]))
    else $error("burst changed the upper address bits");

  // A blocked edge leaves the counter, address and pending write alone.
  a_suspend_keeps: assert property (
    !enabled |=> $stable(cnt_r) && $stable(acc_addr_r) && $stable(wr_pend_r))
    else $error("suspended edge changed burst state");

  c_burst_read: cover property (do_load && cmd.read ##1 do_adv[*3]);
  c_read_write: cover property (do_load && cmd.read ##1 do_load && !cmd.read ##1 do_load);
  c_suspend_read: cover property (do_load && cmd.read ##1 !enabled[*2] ##1 enabled);
  c_desel_noop: cover property (do_desel ##1 enabled && cmd.adv);
  c_write_burst: cover property (do_load && !cmd.read ##1 do_adv[*3]);

endmodule

`default_nettype wire

// ===== testbench/ctrl_model.sv
// Memory controller model that issues commands and owns the write data lines.
`default_nettype none
`timescale 1ns/100ps

module ctrl_model
  import sram_port_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   clk_gate_n,
  output logic                   select_a_n,
  output logic                   select_b,
  output logic                   select_c_n,
  output logic                   read_not_write,
  output logic                   advance_or_load,
  output logic [LANES-1:0]       lane_write_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      dq_i
);
  logic wr_mode;  // The access in progress is a write.
  logic wr_due;   // The next enabled beat carries write data.

  // Deselected with the clock enabled at time zero, so no edge is blocked
  // before the first read has put a defined word on the bus.
  initial begin
    {clk_gate_n, select_a_n, select_b, select_c_n} = 4'h3;
    {read_not_write, advance_or_load, lane_write_n, addr} = {2'h2, 4'hF, 18'h00000};
    {dq_i, wr_mode, wr_due} = '0;
  end

  // ------------------------------------------------------------------
  // One command beat
  // ------------------------------------------------------------------
  // Drives at the falling edge so the rising edge samples settled values.
  // The data lines toggle when no write owns them, so a stale word never looks valid.
  task automatic beat(input logic g, input logic [2:0] s, input logic rnw, input logic adv,
                      input logic [LANES-1:0] ln, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd);
    @(negedge clk_sys);
    clk_gate_n = g;
    {select_a_n, select_b, select_c_n} = s;
    {read_not_write, advance_or_load, lane_write_n, addr} = {rnw, adv, ln, a};
    dq_i = wr_due ? wd : ~dq_i;
    @(posedge clk_sys);
    #2;
    if (!g) begin
      if (!adv) wr_mode = (s == 3'b010) && !rnw;
      wr_due = wr_mode;
    end
  endtask
endmodule

`default_nettype wire

// ===== testbench/sram_port_bench.sv
// Self-checking bench of the SRAM port driven through the controller model.
`default_nettype none
`timescale 1ns/100ps

module sram_port_bench
  import sram_port_pkg::*;
;
  localparam logic [2:0] SEL = 3'b010;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              burst_order_sel = 1'b0;
  logic              gn, an, bs, cn, rnw, adv, oe;
  logic [LANES-1:0]  ln;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] di, dq_o;
  int                num_errors = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #10 clk_sys = ~clk_sys;

  ctrl_model ctrl_model_i (.clk_sys(clk_sys), .clk_gate_n(gn), .select_a_n(an), .select_b(bs),
    .select_c_n(cn), .read_not_write(rnw), .advance_or_load(adv), .lane_write_n(ln),
    .addr(a), .dq_i(di));

  sram_port sram_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_gate_n(gn),
    .select_a_n(an), .select_b(bs), .select_c_n(cn), .read_not_write(rnw),
    .advance_or_load(adv), .lane_write_n(ln), .burst_order_sel(burst_order_sel), .addr(a),
    .dq_i(di), .dq_o(dq_o), .dq_oe(oe));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input logic g, input logic [2:0] s, input logic r, input logic ad,
                     input logic [3:0] l, input logic [17:0] ad_in, input logic [35:0] wd);
    ctrl_model_i.beat(g, s, r, ad, l, ad_in, wd);
  endtask

  // Word stored at each address, so a wrong beat order shows as a wrong word.
  function automatic logic [35:0] pat(input logic [17:0] ad_in);
    pat = {18'h2A5A5, ad_in};
  endfunction

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Linear write burst from start 2; read/write is held high to prove it is ignored.
  task automatic t_write_linear;
    cyc(0, SEL, 0, 0, 4'h0, 18'h00102, '0);
    for (int k = 0; k < 4; k++) begin
      cyc(0, (k == 3) ? 3'b110 : SEL, 1, k != 3, 4'h0, '0, pat({16'h0040, 2'(2 + k)}));
    end
  endtask

  // Interleaved read burst from start 1, six beats to cross the wrap.
  task automatic t_read_interleave;
    @(negedge clk_sys);
    burst_order_sel = 1'b1;
    cyc(0, SEL, 1, 0, 4'hF, 18'h00101, '0);
    for (int k = 0; k < 6; k++) begin
      chk("dq_o", pat({16'h0040, 2'(1 ^ k)}), dq_o);
      chk("dq_oe", 36'h1, 36'(oe));
      cyc(0, SEL, 0, 1, 4'h0, '0, '0);
    end
    cyc(0, SEL, 1, 0, 4'hF, 18'h00103, '0);
    chk("dq_o", pat(18'h00103), dq_o);
    cyc(0, 3'b110, 1, 0, 4'hF, '0, '0);
    chk("dq_oe", 36'h0, 36'(oe));
    cyc(0, SEL, 1, 1, 4'hF, '0, '0);
    chk("dq_oe", 36'h0, 36'(oe));
  endtask

  // Back-to-back writes with partial and empty lane masks, then alternating traffic.
  task automatic t_lanes;
    cyc(0, SEL, 0, 0, 4'h0, 18'h00200, '0);
    cyc(0, SEL, 0, 0, 4'hA, 18'h00200, '1);
    cyc(0, SEL, 0, 0, 4'hF, 18'h00200, '0);
    cyc(0, SEL, 1, 0, 4'hF, 18'h00200, '0);
    chk("dq_o", 36'hA_FF00_FF00, dq_o);
    cyc(0, SEL, 0, 0, 4'h0, 18'h00201, '0);
    chk("dq_oe", 36'h0, 36'(oe));
    cyc(0, SEL, 1, 0, 4'hF, 18'h00200, 36'h9_8765_4321);
    chk("dq_o", 36'hA_FF00_FF00, dq_o);
    cyc(0, SEL, 1, 0, 4'hF, 18'h00201, '0);
    chk("dq_o", 36'h9_8765_4321, dq_o);
  endtask

  // Suspended edges carry a selected write that must not land; each false enable deselects.
  task automatic t_suspend_select;
    logic [2:0] off [3];
    off = '{3'b110, 3'b000, 3'b011};
    repeat (2) begin
      cyc(1, SEL, 0, 0, 4'h0, 18'h00200, '0);
      chk("dq_o", 36'h9_8765_4321, dq_o);
      chk("dq_oe", 36'h1, 36'(oe));
    end
    foreach (off[i]) begin
      cyc(0, off[i], 1, 0, 4'hF, 18'h00200, '0);
      chk("dq_oe", 36'h0, 36'(oe));
    end
    cyc(0, SEL, 1, 0, 4'hF, 18'h00200, '0);
    chk("dq_o", 36'hA_FF00_FF00, dq_o);
  endtask

  // A hang ends the run as a mismatch; the tests need well under a hundred cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      close_out();
    end
  end

  // Reset for four cycles, then the scenarios in order.
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    #2;
    chk("dq_oe", 36'h0, 36'(oe));
    t_write_linear();
    t_read_interleave();
    t_lanes();
    t_suspend_select();
    close_out();
  end
endmodule

`default_nettype wire
